// [rtl/fifo_offset_program_retransmit.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ofs_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Two-edge countdown: load restarts it, each step edge counts down,
// done pulses on the edge that reaches zero.
module edge_countdown (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // Control
   input  wire logic load,
   input  wire logic step,
   output wire logic done
);
   logic [1:0] cnt_ff;
   logic [1:0] nxt_cnt;

   assign done = step & ~load & (cnt_ff == `CNT_ONE);
   assign nxt_cnt = load ? `FLAG_DELAY :
                    (step && cnt_ff != `CNT_ZERO) ? cnt_ff - `CNT_ONE : cnt_ff;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cnt_ff <= `CNT_ZERO;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
module fifo_offset_program_retransmit
   import fifo_ofs_pkg::*;
#(
   parameter logic deep_part = 1'b0
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Device pins
   input  wire pins_t             pins,
   // Memory core
   input  wire core_t             core,
   // Offsets and partial flag validity
   output logic [`OFS_W-1:0]      empty_offset,
   output logic [`OFS_W-1:0]      full_offset,
   output logic                   almost_empty_valid,
   output logic                   almost_full_valid,
   // Modes caught at master reset
   output logic                   serial_load_mode,
   output logic                   fall_through_mode_mode,
   // Memory access redirects
   output logic                   mem_write,
   output logic                   mem_read,
   // Data outputs
   output logic [8:0]             data_out,
   output logic                   data_out_load,
   // Retransmit
   output logic                   read_ptr_rewind,
   output logic                   first_word_show,
   output logic                   half_level_update,
   output logic                   almost_empty_update,
   output logic                   almost_full_update,
   output logic                   empty_flag_n,
   output logic                   out_ready_n
);

   /////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; stage three only feeds the clock edge detectors
   pins_t pin_s1_ff;
   pins_t pin_s2_ff;
   pins_t pin_s3_ff;

   always_ff @(posedge sys_clk) begin
      pin_s1_ff <= pins;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
   end

   wire wclk_rise = pin_s2_ff.wclk & ~pin_s3_ff.wclk;
   wire rclk_rise = pin_s2_ff.rclk & ~pin_s3_ff.rclk;
   wire ld_low    = ~pin_s2_ff.load_select_n;
   wire sen_low   = ~pin_s2_ff.shift_gate_n;
   wire wen_low   = ~pin_s2_ff.write_strobe_n;
   wire ren_low   = ~pin_s2_ff.read_strobe_n;
   wire si_bit    = pin_s2_ff.fall_through_mode;
   wire prs       = ~pin_s2_ff.partial_reset_n;

   /////////////////////////////////////////////////////////////////////////////
   // State
   logic [`OFS_W-1:0] empty_off_ff;
   logic [`OFS_W-1:0] full_off_ff;
   logic [`OFS_W-1:0] nxt_empty_off;
   logic [`OFS_W-1:0] nxt_full_off;
   logic [5:0]        ser_idx_ff;
   logic [2:0]        wr_ptr_ff;
   logic [2:0]        rd_ptr_ff;
   logic              serial_ff;
   logic              fall_through_mode_ff;
   logic              pae_valid_ff;
   logic              paf_valid_ff;
   logic              mem_write_ff;
   logic              mem_read_ff;
   logic [8:0]        data_out_ff;
   logic              data_out_load_ff;
   retx_state_t       retx_state_ff;
   retx_state_t       nxt_retx_state;
   logic [1:0]        setup_cnt_ff;
   logic              force_ff;
   logic              rewind_ff;
   logic              first_word_ff;
   logic              hf_upd_ff;
   logic              ae_upd_ff;
   logic              af_upd_ff;
   logic              empty_flag_n_ff;
   logic              out_ready_n_ff;

   /////////////////////////////////////////////////////////////////////////////
   // Sequence geometry for the chosen depth
   wire [5:0] ser_bits  = deep_part ? `SER_BITS_LARGE : `SER_BITS_SMALL;
   wire [5:0] ser_half  = deep_part ? `SER_HALF_LARGE : `SER_HALF_SMALL;
   wire [2:0] par_regs  = deep_part ? `PAR_REGS_LARGE : `PAR_REGS_SMALL;
   wire [2:0] par_half  = par_regs >> 1;

   /////////////////////////////////////////////////////////////////////////////
   // Command decode on the synchronised clock edges
   wire ser_shift = wclk_rise & serial_ff & ld_low & sen_low & ~wen_low;
   wire par_write = wclk_rise & ~serial_ff & ld_low & wen_low;
   wire ofs_read  = rclk_rise & ld_low & ren_low;
   wire wr_mem    = wclk_rise & ~ld_low & wen_low;
   wire rd_mem    = rclk_rise & ~ld_low & ren_low;

   wire ser_last  = ser_idx_ff == ser_bits - 6'h01;
   wire ser_first = ser_idx_ff == `IDX_FIRST;
   wire ser_full  = ser_idx_ff >= ser_half;
   wire [5:0] ser_pos = ser_full ? ser_idx_ff - ser_half : ser_idx_ff;

   wire wr_full   = wr_ptr_ff >= par_half;
   wire [2:0] wr_byte = wr_full ? wr_ptr_ff - par_half : wr_ptr_ff;
   wire wr_last   = wr_ptr_ff == par_regs - 3'h1;
   wire rd_full   = rd_ptr_ff >= par_half;
   wire [2:0] rd_byte = rd_full ? rd_ptr_ff - par_half : rd_ptr_ff;
   wire rd_last   = rd_ptr_ff == par_regs - 3'h1;

   /////////////////////////////////////////////////////////////////////////////
   // Offset register update
   wire [`OFS_W-1:0] wr_merged_e;
   wire [`OFS_W-1:0] wr_merged_f;
   wire [7:0]        din = pin_s2_ff.data_in[7:0];

   assign wr_merged_e = (wr_byte == 3'h0) ? {empty_off_ff[16:8], din} :
                        (wr_byte == 3'h1) ? {empty_off_ff[16], din, empty_off_ff[7:0]} :
                                            {din[0], empty_off_ff[15:0]};
   assign wr_merged_f = (wr_byte == 3'h0) ? {full_off_ff[16:8], din} :
                        (wr_byte == 3'h1) ? {full_off_ff[16], din, full_off_ff[7:0]} :
                                            {din[0], full_off_ff[15:0]};

   always_comb begin
      nxt_empty_off = empty_off_ff;
      nxt_full_off  = full_off_ff;
      if (ser_shift) begin
         if (ser_full) begin
            nxt_full_off[ser_pos[4:0]] = si_bit;
         end else begin
            nxt_empty_off[ser_pos[4:0]] = si_bit;
         end
      end else if (par_write) begin
         if (wr_full) begin
            nxt_full_off = wr_merged_f;
         end else begin
            nxt_empty_off = wr_merged_e;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         // Straps follow the synchronised pins while master reset is held
         serial_ff    <= pin_s2_ff.load_select_n;
         fall_through_mode_ff      <= pin_s2_ff.fall_through_mode;
         empty_off_ff <= pin_s2_ff.load_select_n ? `DFLT_SERIAL : `DFLT_PARALLEL;
         full_off_ff  <= pin_s2_ff.load_select_n ? `DFLT_SERIAL : `DFLT_PARALLEL;
      end else begin
         empty_off_ff <= nxt_empty_off;
         full_off_ff  <= nxt_full_off;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Sequence pointers; partial reset leaves them alone
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ser_idx_ff <= `IDX_FIRST;
         wr_ptr_ff  <= `PTR_FIRST;
         rd_ptr_ff  <= `PTR_FIRST;
      end else begin
         if (ser_shift) begin
            ser_idx_ff <= ser_last ? `IDX_FIRST : ser_idx_ff + 6'h01;
         end
         if (par_write) begin
            wr_ptr_ff <= wr_last ? `PTR_FIRST : wr_ptr_ff + 3'h1;
         end
         if (ofs_read) begin
            rd_ptr_ff <= rd_last ? `PTR_FIRST : rd_ptr_ff + 3'h1;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Partial flag validity
   // A flag falls invalid when programming begins and comes back two edges of
   // its own clock after its last parallel word, or after the last serial bit of both offsets.
   wire flags_drop = (ser_shift & ser_first) | (par_write & (wr_ptr_ff == `PTR_FIRST));
   wire pae_done   = (ser_shift & ser_last) |
                     (par_write & (wr_ptr_ff == par_half - 3'h1));
   wire paf_done   = (ser_shift & ser_last) | (par_write & wr_last);
   wire pae_ready;
   wire paf_ready;

   edge_countdown pae_delay (
      .sys_clk (sys_clk),
      .rst     (rst | flags_drop),
      .load    (pae_done),
      .step    (rclk_rise),
      .done    (pae_ready)
   );

   edge_countdown paf_delay (
      .sys_clk (sys_clk),
      .rst     (rst | flags_drop),
      .load    (paf_done),
      .step    (wclk_rise),
      .done    (paf_ready)
   );

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pae_valid_ff <= 1'b1;
         paf_valid_ff <= 1'b1;
      end else begin
         if (flags_drop) begin
            pae_valid_ff <= 1'b0;
         end else if (pae_ready) begin
            pae_valid_ff <= 1'b1;
         end
         if (flags_drop) begin
            paf_valid_ff <= 1'b0;
         end else if (paf_ready) begin
            paf_valid_ff <= 1'b1;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Readback and output data register
   wire [`OFS_W-1:0] rd_sel  = rd_full ? full_off_ff : empty_off_ff;
   wire [7:0]        rd_data = (rd_byte == 3'h0) ? rd_sel[7:0] :
                               (rd_byte == 3'h1) ? rd_sel[15:8] :
                                                   {7'h00, rd_sel[16]};

   always_ff @(posedge sys_clk) begin
      if (rst || prs) begin
         data_out_ff      <= `DATA_ZERO;
         data_out_load_ff <= 1'b0;
         mem_write_ff     <= 1'b0;
         mem_read_ff      <= 1'b0;
      end else begin
         mem_write_ff     <= wr_mem;
         mem_read_ff      <= rd_mem;
         data_out_load_ff <= ofs_read;
         // The offset byte wins over a word from the core in the same cycle
         if (ofs_read) begin
            data_out_ff <= {1'b0, rd_data};
         end else if (core.q_valid) begin
            data_out_ff <= core.q;
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Retransmit setup
   wire retx_start = rclk_rise & ~pin_s2_ff.replay_request_n &
                     (retx_state_ff == RETX_IDLE);
   wire setup_end  = rclk_rise & (setup_cnt_ff == `CNT_ONE);
   wire ae_hit;
   wire af_hit;

   always_comb begin
      case (retx_state_ff)
         RETX_IDLE:  nxt_retx_state = retx_start ? RETX_SETUP : RETX_IDLE;
         RETX_SETUP: nxt_retx_state = setup_end ? RETX_DONE : RETX_SETUP;
         RETX_DONE:  nxt_retx_state = RETX_IDLE;
         default:    nxt_retx_state = RETX_IDLE;
      endcase
   end

   edge_countdown ae_update (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (retx_start),
      .step    (rclk_rise),
      .done    (ae_hit)
   );

   edge_countdown af_update (
      .sys_clk (sys_clk),
      .rst     (rst),
      .load    (retx_start),
      .step    (wclk_rise),
      .done    (af_hit)
   );

   always_ff @(posedge sys_clk) begin
      if (rst || prs) begin
         retx_state_ff <= RETX_IDLE;
         setup_cnt_ff  <= `CNT_ZERO;
         force_ff      <= 1'b0;
         rewind_ff     <= 1'b0;
         first_word_ff <= 1'b0;
         hf_upd_ff     <= 1'b0;
         ae_upd_ff     <= 1'b0;
         af_upd_ff     <= 1'b0;
      end else begin
         retx_state_ff <= nxt_retx_state;
         rewind_ff     <= retx_start;
         hf_upd_ff     <= retx_start;
         ae_upd_ff     <= ae_hit;
         af_upd_ff     <= af_hit;
         first_word_ff <= (retx_state_ff == RETX_DONE) & fall_through_mode_ff;
         if (retx_start) begin
            setup_cnt_ff <= `RETX_SETUP_EDGES;
            force_ff     <= 1'b1;
         end else if (rclk_rise && setup_cnt_ff != `CNT_ZERO) begin
            setup_cnt_ff <= setup_cnt_ff - `CNT_ONE;
         end
         if (retx_state_ff == RETX_DONE) begin
            force_ff <= 1'b0;
         end
      end
   end

   // Empty flag held low in standard mode, output ready held inactive in
   // fall-through mode, for the length of the setup
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         empty_flag_n_ff <= 1'b0;
         out_ready_n_ff  <= 1'b1;
      end else begin
         empty_flag_n_ff <= core.empty_n & ~(force_ff & ~fall_through_mode_ff);
         out_ready_n_ff  <= core.out_ready_n | (force_ff & fall_through_mode_ff);
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign empty_offset        = empty_off_ff;
   assign full_offset         = full_off_ff;
   assign almost_empty_valid  = pae_valid_ff;
   assign almost_full_valid   = paf_valid_ff;
   assign serial_load_mode    = serial_ff;
   assign fall_through_mode_mode           = fall_through_mode_ff;
   assign mem_write           = mem_write_ff;
   assign mem_read            = mem_read_ff;
   assign data_out            = data_out_ff;
   assign data_out_load       = data_out_load_ff;
   assign read_ptr_rewind     = rewind_ff;
   assign first_word_show     = first_word_ff;
   assign half_level_update   = hf_upd_ff;
   assign almost_empty_update = ae_upd_ff;
   assign almost_full_update  = af_upd_ff;
   assign empty_flag_n        = empty_flag_n_ff;
   assign out_ready_n         = out_ready_n_ff;

endmodule

`default_nettype wire

// [rtl/fifo_ofs_consts.svh]
`ifndef FIFO_OFS_CONSTS_SVH
`define FIFO_OFS_CONSTS_SVH

// Offset register width: 17 bits for both depths; the smaller depth loads only the low 16
`define OFS_W            17
`define SER_BITS_SMALL   6'h20
`define SER_BITS_LARGE   6'h22
`define SER_HALF_SMALL   6'h10
`define SER_HALF_LARGE   6'h11
`define PAR_REGS_SMALL   3'h4
`define PAR_REGS_LARGE   3'h6
`define PTR_FIRST        3'h0
`define IDX_FIRST        6'h00
// Default offsets picked by the load select strap at master reset
`define DFLT_SERIAL      17'h003ff
`define DFLT_PARALLEL    17'h0007f
// Edges from the completing edge to a valid or updated partial flag
`define FLAG_DELAY       2'h2
// Read-clock edges spent in retransmit setup
`define RETX_SETUP_EDGES 2'h2
`define CNT_ZERO         2'h0
`define CNT_ONE          2'h1
`define DATA_ZERO        9'h000

`endif

// [rtl/fifo_ofs_pkg.sv]
package fifo_ofs_pkg;

   // Device pins, all asynchronous to sys_clk
   typedef struct packed {
      logic       wclk;
      logic       rclk;
      logic       load_select_n;
      logic       shift_gate_n;
      logic       write_strobe_n;
      logic       read_strobe_n;
      logic       replay_request_n;
      logic       fall_through_mode;
      logic       partial_reset_n;
      logic [8:0] data_in;
   } pins_t;

   // Memory core side, on sys_clk
   typedef struct packed {
      logic [8:0] q;
      logic       q_valid;
      logic       empty_n;
      logic       out_ready_n;
   } core_t;

   typedef enum logic [1:0] {
      RETX_IDLE  = 2'b00,
      RETX_SETUP = 2'b01,
      RETX_DONE  = 2'b10
   } retx_state_t;

endpackage

// [verification/fifo_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module fifo_host_model
   import fifo_ofs_pkg::*;
(
   // Clock
   input  wire logic sys_clk,
   // Device pins
   output var pins_t pins
);
   initial begin
      pins = '0;
      {pins.load_select_n, pins.shift_gate_n, pins.write_strobe_n} = 3'h7;
      {pins.read_strobe_n, pins.replay_request_n, pins.partial_reset_n} = 3'h7;
   end

   // Straps must stay put through the whole master reset
   task automatic strap(input logic ld_n, input logic ft);
      @(posedge sys_clk);
      pins.load_select_n <= ld_n;
      pins.fall_through_mode <= ft;
   endtask

   // One clock pulse on one side only, so offset reads and writes never meet
   task automatic op(input logic wr, input logic [4:0] c, input logic si, input logic [8:0] d);
      @(posedge sys_clk);
      {pins.load_select_n, pins.shift_gate_n, pins.write_strobe_n} <= c[4:2];
      {pins.read_strobe_n, pins.replay_request_n} <= c[1:0];
      pins.fall_through_mode <= si;
      pins.data_in <= d;
      repeat (4) @(posedge sys_clk);
      pins.wclk <= wr;
      pins.rclk <= ~wr;
      repeat (4) @(posedge sys_clk);
      pins.wclk <= 1'b0;
      pins.rclk <= 1'b0;
      // Hold time over: lines stop showing the last value
      pins.data_in <= ~d;
      pins.fall_through_mode <= ~si;
      {pins.load_select_n, pins.shift_gate_n, pins.write_strobe_n} <= 3'h7;
      {pins.read_strobe_n, pins.replay_request_n} <= 2'h3;
      repeat (4) @(posedge sys_clk);
   endtask

   task automatic prst();
      @(posedge sys_clk);
      pins.partial_reset_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      pins.partial_reset_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule

`default_nettype wire

// [verification/fifo_offset_program_retransmit_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ofs_consts.svh"

module fifo_offset_program_retransmit_test
   import fifo_ofs_pkg::*;
;
   // Codes {load_select_n, shift_gate_n, write_strobe_n, read_strobe_n, replay_request_n}
   localparam logic [4:0] PWR = 5'h0b, PRD = 5'h0d, SHF = 5'h07, MWR = 5'h1b, MRD = 5'h1d;
   localparam logic [4:0] NOP = 5'h1f, HLD1 = 5'h0f, HLD2 = 5'h17, RTX = 5'h1e;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   core_t       core;
   pins_t       pins;
   logic [16:0] empty_offset, full_offset;
   logic [8:0]  data_out;
   logic        almost_empty_valid, almost_full_valid, serial_load_mode, fall_through_mode_mode;
   logic        mem_write, mem_read, data_out_load, read_ptr_rewind, first_word_show;
   logic        half_level_update, almost_empty_update, almost_full_update;
   logic        empty_flag_n, out_ready_n;
   logic [31:0] seed = 32'h5f23;
   int          e_ofs, f_ofs, wr_ptr, rd_ptr, cyc, error_cnt, num_checks;
   int          n_mw, n_mr, n_rw, n_sh, n_ae, n_af;
   int          bits_q[$];

   always #25 sys_clk = ~sys_clk;

   fifo_host_model fifo_host_model_inst (.sys_clk(sys_clk), .pins(pins));
   fifo_offset_program_retransmit #(.deep_part(1'b1)) fifo_offset_program_retransmit_inst (.*);

   always @(posedge sys_clk) begin
      n_mw += int'(mem_write);
      n_mr += int'(mem_read);
      n_rw += int'(read_ptr_rewind);
      n_sh += int'(first_word_show);
      n_ae += int'(almost_empty_update);
      n_af += int'(almost_full_update);
      cyc += 1;
      if (cyc > 20000) begin
         error_cnt += 1;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] get_byte(input int idx);
      return (((idx < 3) ? e_ofs : f_ofs) >> (8 * (idx % 3))) & 32'hff;
   endfunction

   task automatic put_byte(input logic [7:0] d);
      int sh;
      int v;
      sh = 8 * (wr_ptr % 3);
      v = (wr_ptr < 3) ? e_ofs : f_ofs;
      v = ((v & ~(32'hff << sh)) | (int'(d) << sh)) & 32'h1ffff;
      if (wr_ptr < 3)
         e_ofs = v;
      else
         f_ofs = v;
      wr_ptr = (wr_ptr + 1) % 6;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      num_checks += 1;
      if (got !== exp) begin
         error_cnt += 1;
         $display("BAD %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   task automatic chk_cnt(input string nm, input int exp, input int got);
      num_checks += 1;
      if (got != exp) begin
         error_cnt += 1;
         $display("BAD %s expected %0d seen %0d", nm, exp, got);
      end
   endtask

   task automatic pin_op(input logic wr, input logic [4:0] c, input logic si, input logic [8:0] d);
      fifo_host_model_inst.op(wr, c, si, d);
   endtask

   task automatic noop(input int n);
      repeat (n) begin
         pin_op(1'b1, NOP, 1'b0, 9'h000);
         pin_op(1'b0, NOP, 1'b0, 9'h000);
      end
   endtask

   task automatic mreset(input logic ld_n, input logic ft);
      fifo_host_model_inst.strap(ld_n, ft);
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      e_ofs = ld_n ? `DFLT_SERIAL : `DFLT_PARALLEL;
      f_ofs = e_ofs;
      wr_ptr = 0;
      rd_ptr = 0;
      chk("empty_offset", e_ofs, empty_offset);
      chk("full_offset", f_ofs, full_offset);
      chk("serial_load_mode", ld_n, serial_load_mode);
      chk("fall_through_mode_mode", ft, fall_through_mode_mode);
   endtask

   task automatic readback(input int n);
      repeat (n) begin
         pin_op(1'b0, PRD, 1'b0, 9'h000);
         chk("data_out", get_byte(rd_ptr), data_out);
         rd_ptr = (rd_ptr + 1) % 6;
      end
   endtask

   task automatic retx(input logic ft);
      pin_op(1'b1, MWR, 1'b0, 9'h011);
      {n_rw, n_sh, n_ae, n_af} = '0;
      pin_op(1'b0, RTX, 1'b0, 9'h000);
      chk("empty_flag_n", ft, empty_flag_n);
      chk("out_ready_n", 32'h1, out_ready_n | !ft);
      noop(3);
      chk("empty_flag_n", 32'h1, empty_flag_n);
      chk("out_ready_n", 32'h0, out_ready_n);
      chk_cnt("read_ptr_rewind", 1, n_rw);
      chk_cnt("first_word_show", int'(ft), n_sh);
      chk_cnt("almost_empty_update", 1, n_ae);
      chk_cnt("almost_full_update", 1, n_af);
   endtask

   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core = '{q: 9'h000, q_valid: 1'b0, empty_n: 1'b1, out_ready_n: 1'b0};
      mreset(1'b0, 1'b0);
      readback(7);
      // Parallel load split by a memory write and a strobe pause; seventh write wraps
      for (int i = 0; i < 7; i++) begin
         if (i == 2) begin
            pin_op(1'b1, MWR, 1'b0, 9'h155);
            pin_op(1'b1, HLD1, 1'b0, 9'h0aa);
         end
         seed = lfsr(seed);
         pin_op(1'b1, PWR, 1'b0, seed[8:0]);
         put_byte(seed[7:0]);
         if (i == 0)
            chk("almost_full_valid", 32'h0, almost_full_valid);
         if (i == 5) begin
            noop(2);
            chk("almost_empty_valid", 32'h1, almost_empty_valid);
            chk("almost_full_valid", 32'h1, almost_full_valid);
         end
      end
      pin_op(1'b1, SHF, 1'b1, 9'h000);
      chk("empty_offset", e_ofs, empty_offset);
      chk("full_offset", f_ofs, full_offset);
      chk_cnt("mem_write", 1, n_mw);
      @(posedge sys_clk);
      core.q_valid <= 1'b1;
      core.q <= 9'h1c3;
      @(posedge sys_clk);
      core.q_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("data_out", 32'h1c3, data_out);
      readback(2);
      pin_op(1'b0, MRD, 1'b0, 9'h000);
      readback(2);
      chk_cnt("mem_read", 1, n_mr);
      fifo_host_model_inst.prst();
      chk("data_out", 32'h0, data_out);
      readback(3);
      retx(1'b0);
      // Serial load in fall-through mode, twice to prove a full reprogram
      mreset(1'b1, 1'b1);
      repeat (2) begin
         for (int i = 0; i < 34; i++) begin
            seed = lfsr(seed);
            if (i == 5)
               pin_op(1'b1, HLD1, ~seed[0], 9'h000);
            if (i == 9)
               pin_op(1'b1, HLD2, ~seed[0], 9'h000);
            if (i == 12)
               pin_op(1'b1, MWR, ~seed[0], seed[8:0]);
            pin_op(1'b1, SHF, seed[0], 9'h000);
            bits_q.push_back(int'(seed[0]));
            if (i == 1)
               chk("partial_valid", 32'h0, {almost_empty_valid, almost_full_valid});
         end
         for (int k = 0; k < 34; k++) begin
            if (k < 17)
               e_ofs[k] = bits_q.pop_front();
            else
               f_ofs[k - 17] = bits_q.pop_front();
         end
      end
      pin_op(1'b1, PWR, 1'b0, 9'h0ff);
      noop(2);
      chk("almost_empty_valid", 32'h1, almost_empty_valid);
      chk("almost_full_valid", 32'h1, almost_full_valid);
      chk("empty_offset", e_ofs, empty_offset);
      chk("full_offset", f_ofs, full_offset);
      readback(6);
      retx(1'b1);
      summarize();
   end
endmodule

`default_nettype wire

// [verification/fifo_ofs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ofs_consts.svh"

module fifo_ofs_chk
   import fifo_ofs_pkg::*;
#(
   parameter logic deep_part = 1'b0
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // Pins
   input  wire pins_t             pins,
   // Results
   input  wire logic [`OFS_W-1:0] empty_offset,
   input  wire logic [`OFS_W-1:0] full_offset,
   input  wire logic              almost_empty_valid,
   input  wire logic              almost_full_valid,
   input  wire logic              serial_load_mode,
   input  wire logic              fall_through_mode_mode,
   input  wire logic              mem_write,
   input  wire logic [8:0]        data_out,
   input  wire logic              data_out_load,
   input  wire logic              read_ptr_rewind,
   input  wire logic              half_level_update,
   input  wire logic              almost_empty_update,
   input  wire logic              almost_full_update,
   input  wire logic              empty_flag_n,
   input  wire logic              out_ready_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the readback pointer
   logic      [2:0]  rd_idx_ff;
   wire logic [2:0]  half_regs  = deep_part ? 3'h3 : 3'h2;
   wire logic [2:0]  last_idx   = deep_part ? 3'h5 : 3'h3;
   wire logic        in_full    = rd_idx_ff >= half_regs;
   wire logic [2:0]  byte_no    = in_full ? rd_idx_ff - half_regs : rd_idx_ff;
   wire logic [16:0] sel_ofs    = in_full ? full_offset : empty_offset;
   wire logic [7:0]  exp_byte   = (byte_no == 3'h0) ? sel_ofs[7:0] :
                                  (byte_no == 3'h1) ? sel_ofs[15:8] : {7'h00, sel_ofs[16]};
   wire logic [2:0]  nxt_rd_idx = (rd_idx_ff == last_idx) ? 3'h0 : rd_idx_ff + 3'h1;

   always_ff @(posedge sys_clk) begin
      if (rst)
         rd_idx_ff <= 3'h0;
      else if (data_out_load)
         rd_idx_ff <= nxt_rd_idx;
   end

   ////////////////////////////////////////////////////////////////////////////////
   sequence setup_start;
      read_ptr_rewind && half_level_update;
   endsequence
   sequence ae_quiet;
      !almost_empty_update [*3];
   endsequence

   a_readback_byte: assert property (data_out_load |-> data_out == {1'b0, exp_byte})
      else $error("readback byte wrong");
   a_readback_cause: assert property (data_out_load |->
      !$past(pins.load_select_n, 3) && !$past(pins.read_strobe_n, 3) && $past(pins.rclk, 3))
      else $error("readback without command");
   a_rewind_cause: assert property (read_ptr_rewind |->
      half_level_update && !$past(pins.replay_request_n, 3) && $past(pins.rclk, 3))
      else $error("rewind without replay");
   a_ef_forced: assert property (setup_start ##0 !fall_through_mode_mode |=> !empty_flag_n [*2])
      else $error("empty flag not low in setup");
   a_or_forced: assert property (setup_start ##0 fall_through_mode_mode |=> out_ready_n [*2])
      else $error("output ready not forced");
   a_ae_update: assert property (setup_start |=> ae_quiet ##[1:150] almost_empty_update)
      else $error("almost empty update off time");
   a_af_update: assert property (setup_start |-> ##[2:150] almost_full_update)
      else $error("almost full update missing");
   a_mode_fixed: assert property (!$past(rst) |-> $stable(serial_load_mode) && $stable(fall_through_mode_mode))
      else $error("mode changed");
   a_reset_dflt: assert property ($fell(rst) |-> almost_empty_valid && almost_full_valid &&
      empty_offset == (serial_load_mode ? `DFLT_SERIAL : `DFLT_PARALLEL) && full_offset == empty_offset)
      else $error("wrong defaults");
   a_mem_redirect: assert property (mem_write |->
      $past(pins.load_select_n, 3) && !$past(pins.write_strobe_n, 3))
      else $error("bad memory write");
   a_valid_settle: assert property ($rose(almost_full_valid) |-> $past(full_offset, 6) == full_offset)
      else $error("full flag valid too soon");
endmodule

bind fifo_offset_program_retransmit fifo_ofs_chk #(.deep_part(deep_part))
   fifo_ofs_chk_inst (.*);

`default_nettype wire
